/* design/scd_command_decode.sv */
// How it works
// - pattern mode off: reads and writes go to the array, location ignored
// - pattern mode on: a read is redirected to the selected pattern unless a pattern burst is already running
// - pattern reads drive the pattern bit on bit 0 of both lanes
// - bits 7..1 of each lane copy bit 0 or read zero, fixed option
// - eight-beat pattern reads: column bit 2 zero, beats 0 to 7 in order
// - chopped pattern reads: column bit 2 picks beats 0-3 or 4-7
// - pattern reads ignore bank, column 9..3, autoprecharge, high bits other than the chop bit
// - chop select bit honoured only when mode zero enables on-the-fly
// - pattern reads use the normal read latency
// - location zero returns 0,1,0,1... for both burst lengths
// - beat 0 is the pattern lsb, beat 7 its msb
// - write decode, autoprecharge bit picks plain or auto-close variant
// - on-the-fly writes: chop bit low chops to four, high gives eight
// - read decode, autoprecharge bit picks plain or auto-close variant
// - on-the-fly reads: chop bit low chops to four, high gives eight
// - command pins sampled at the rising edge of the link clock
// - deselect acts as no-op and never ends a running burst
// - pattern mode turns read with autoprecharge into a plain read
module scd_command_decode (
    // system
    input wire logic clk,
    input wire logic resetn,
    // memory command pins, asynchronous to clk
    input wire logic memClk,
    input wire scd_pkg::scd_pins_s memPins,
    // read data lanes
    output logic [scd_pkg::DQ_W-1:0] dqOut,
    output logic dqOe,
    // decoded commands
    output scd_pkg::scd_cmd_s cmdOut,
    output logic cmdValid,
    // status
    output logic patternOn,
    output scd_pkg::scd_power_e powerState
);

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers, then edge finding on the link clock
    logic clkSync1, clkSync2, clkPrev;
    scd_pkg::scd_pins_s pinSync1, pinSync2;
    logic linkRise, linkEdge;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clkSync1 <= 1'b0;
            clkSync2 <= 1'b0;
            clkPrev <= 1'b0;
            pinSync1 <= '0;
            pinSync2 <= '0;
        end else begin
            clkSync1 <= memClk;
            clkSync2 <= clkSync1;
            clkPrev <= clkSync2;
            pinSync1 <= memPins;
            pinSync2 <= pinSync1;
        end
    end

    // pins share the clock's delay, so they line up with the found edge
    assign linkRise = clkSync2 & ~clkPrev;
    assign linkEdge = clkSync2 ^ clkPrev;

    ////////////////////////////////////////////////////////////////////////
    // command truth table; power state resolves which exit is meant
    function automatic scd_pkg::scd_cmd_e decodeCmd(
        input scd_pkg::scd_pins_s p,
        input logic ckeWas,
        input scd_pkg::scd_power_e pwr
    );
        logic [2:0] rcw;
        logic ap;
        logic idleBus;
        rcw = {p.rasN, p.casN, p.weN};
        ap = p.addr[scd_pkg::AP_BIT];
        idleBus = p.csN | (rcw == 3'h7);
        decodeCmd = scd_pkg::CMD_ILLEGAL;
        if (ckeWas && p.cke) begin
            if (p.csN) begin
                decodeCmd = scd_pkg::CMD_DESELECT;
            end else begin
                case (rcw)
                    3'h0: decodeCmd = scd_pkg::CMD_MODE_SET;
                    3'h1: decodeCmd = scd_pkg::CMD_REFRESH;
                    3'h2: decodeCmd = ap ? scd_pkg::CMD_ALL_BANK_CLOSE
                                         : scd_pkg::CMD_PRECHARGE;
                    3'h3: decodeCmd = scd_pkg::CMD_ROW_OPEN;
                    3'h4: decodeCmd = ap ? scd_pkg::CMD_WRITE_AUTOCLOSE
                                         : scd_pkg::CMD_WRITE;
                    3'h5: decodeCmd = ap ? scd_pkg::CMD_READ_AUTOCLOSE
                                         : scd_pkg::CMD_READ;
                    3'h6: decodeCmd = ap ? scd_pkg::CMD_LONG_CAL
                                         : scd_pkg::CMD_SHORT_CAL;
                    default: decodeCmd = scd_pkg::CMD_NOP;
                endcase
            end
        end else if (ckeWas) begin
            if (idleBus) begin
                decodeCmd = scd_pkg::CMD_POWER_DOWN_ENTRY;
            end else if (rcw == 3'h1) begin
                decodeCmd = scd_pkg::CMD_SELF_REF_ENTRY;
            end
        end else if (p.cke) begin
            if (idleBus) begin
                decodeCmd = (pwr == scd_pkg::PWR_SELF_REF)
                          ? scd_pkg::CMD_SELF_REF_EXIT
                          : scd_pkg::CMD_POWER_DOWN_EXIT;
            end
        end else begin
            decodeCmd = scd_pkg::CMD_HOLD_LOW;
        end
    endfunction : decodeCmd

    // pattern chosen by the location field; unused locations read zero
    function automatic logic [7:0] patternFor(input logic [1:0] loc);
        patternFor = (loc == scd_pkg::LOC_PREDEF) ? scd_pkg::PATTERN_LOC0
                                                  : scd_pkg::PATTERN_RFU;
    endfunction : patternFor

    ////////////////////////////////////////////////////////////////////////
    // command and mode state
    logic ckePrev, next_ckePrev;
    logic [1:0] burstMode, next_burstMode;
    logic [1:0] patternLoc, next_patternLoc;
    logic next_patternOn, next_cmdValid;
    scd_pkg::scd_power_e next_powerState;
    scd_pkg::scd_cmd_s next_cmdOut;
    scd_pkg::scd_cmd_e rawCmd;
    logic rawChop;
    logic patternRead;

    assign rawCmd = decodeCmd(pinSync2, ckePrev, powerState);
    // chop bit honoured only in on-the-fly mode; low bit means chop
    assign rawChop = (burstMode == scd_pkg::BL_FLY)
                   ? ~pinSync2.addr[scd_pkg::BC_BIT]
                   : (burstMode == scd_pkg::BL_FIXED4);
    assign patternRead = linkRise & patternOn
                       & ((rawCmd == scd_pkg::CMD_READ)
                       | (rawCmd == scd_pkg::CMD_READ_AUTOCLOSE));

    always_comb begin
        next_ckePrev = ckePrev;
        next_burstMode = burstMode;
        next_patternOn = patternOn;
        next_patternLoc = patternLoc;
        next_powerState = powerState;
        next_cmdOut = cmdOut;
        next_cmdValid = 1'b0;
        if (linkRise) begin
            next_ckePrev = pinSync2.cke;
            next_cmdValid = 1'b1;
            next_cmdOut.code = rawCmd;
            next_cmdOut.chop = rawChop;
            next_cmdOut.bank = pinSync2.bank;
            next_cmdOut.addr = pinSync2.addr;
            if (patternOn && rawCmd == scd_pkg::CMD_READ_AUTOCLOSE) begin
                next_cmdOut.code = scd_pkg::CMD_READ;
            end
            case (rawCmd)
                scd_pkg::CMD_MODE_SET: begin
                    if (pinSync2.bank == scd_pkg::MR0_SEL) begin
                        next_burstMode =
                            pinSync2.addr[scd_pkg::MR_FIELD_LSB +: 2];
                    end else if (pinSync2.bank == scd_pkg::MR3_SEL) begin
                        next_patternOn = pinSync2.addr[scd_pkg::MR3_EN_BIT];
                        next_patternLoc =
                            pinSync2.addr[scd_pkg::MR_FIELD_LSB +: 2];
                    end
                end
                scd_pkg::CMD_POWER_DOWN_ENTRY:
                    next_powerState = scd_pkg::PWR_DOWN;
                scd_pkg::CMD_SELF_REF_ENTRY:
                    next_powerState = scd_pkg::PWR_SELF_REF;
                scd_pkg::CMD_POWER_DOWN_EXIT,
                scd_pkg::CMD_SELF_REF_EXIT:
                    next_powerState = scd_pkg::PWR_ACTIVE;
                default: next_powerState = powerState;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ckePrev <= 1'b0;
            burstMode <= scd_pkg::BL_FIXED8;
            patternOn <= 1'b0;
            patternLoc <= scd_pkg::LOC_PREDEF;
            powerState <= scd_pkg::PWR_ACTIVE;
            cmdOut <= '0;
            cmdValid <= 1'b0;
        end else begin
            ckePrev <= next_ckePrev;
            burstMode <= next_burstMode;
            patternOn <= next_patternOn;
            patternLoc <= next_patternLoc;
            powerState <= next_powerState;
            cmdOut <= next_cmdOut;
            cmdValid <= next_cmdValid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pattern read burst: latency wait, then one beat per link edge
    scd_pkg::scd_burst_e burstState, next_burstState;
    logic [3:0] latCnt, next_latCnt;
    logic [2:0] beatIdx, next_beatIdx, beatsLeft, next_beatsLeft;
    logic [2:0] startBeat, next_startBeat;
    logic [7:0] patBits, next_patBits;
    logic [scd_pkg::DQ_W-1:0] next_dqOut;
    logic next_dqOe;
    logic [2:0] driveBeat;
    logic [scd_pkg::LANE_W-1:0] lane;

    always_comb begin
        next_burstState = burstState;
        next_latCnt = latCnt;
        next_beatIdx = beatIdx;
        next_beatsLeft = beatsLeft;
        next_startBeat = startBeat;
        next_patBits = patBits;
        next_dqOe = dqOe;
        driveBeat = beatIdx;
        case (burstState)
            // only bank-free, ap-free fields matter here; rest is ignored
            scd_pkg::BURST_IDLE: begin
                if (patternRead) begin
                    next_burstState = scd_pkg::BURST_WAIT;
                    next_latCnt = scd_pkg::READ_LAT_CYC - 4'h1;
                    next_patBits = patternFor(patternLoc);
                    next_startBeat = (rawChop &&
                        pinSync2.addr[scd_pkg::COL2_BIT])
                        ? scd_pkg::NIBBLE_HI : scd_pkg::BEAT_FIRST;
                    next_beatsLeft = rawChop ? scd_pkg::LEFT_BC4
                                             : scd_pkg::LEFT_BL8;
                end
            end
            // no-op and deselect leave the wait untouched
            scd_pkg::BURST_WAIT: begin
                if (linkRise) begin
                    if (latCnt == 4'h0) begin
                        next_burstState = scd_pkg::BURST_STREAM;
                        next_beatIdx = startBeat;
                        driveBeat = startBeat;
                        next_dqOe = 1'b1;
                    end else begin
                        next_latCnt = latCnt - 4'h1;
                    end
                end
            end
            scd_pkg::BURST_STREAM: begin
                if (linkEdge) begin
                    if (beatsLeft == 3'h0) begin
                        next_burstState = scd_pkg::BURST_IDLE;
                        next_dqOe = 1'b0;
                    end else begin
                        next_beatsLeft = beatsLeft - 3'h1;
                        next_beatIdx = beatIdx + 3'h1;
                        driveBeat = beatIdx + 3'h1;
                    end
                end
            end
            default: next_burstState = scd_pkg::BURST_IDLE;
        endcase
        // beat n takes pattern bit n, lsb first
        lane = scd_pkg::FILL_COPY ? {8{next_patBits[driveBeat]}}
                                  : {7'h00, next_patBits[driveBeat]};
        next_dqOut = next_dqOe ? {lane, lane} : '0;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            burstState <= scd_pkg::BURST_IDLE;
            latCnt <= 4'h0;
            beatIdx <= scd_pkg::BEAT_FIRST;
            beatsLeft <= 3'h0;
            startBeat <= scd_pkg::BEAT_FIRST;
            patBits <= 8'h00;
            dqOut <= '0;
            dqOe <= 1'b0;
        end else begin
            burstState <= next_burstState;
            latCnt <= next_latCnt;
            beatIdx <= next_beatIdx;
            beatsLeft <= next_beatsLeft;
            startBeat <= next_startBeat;
            patBits <= next_patBits;
            dqOut <= next_dqOut;
            dqOe <= next_dqOe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_readSeen;
        linkRise && pinSync2.cke && ckePrev && !pinSync2.csN
            && {pinSync2.rasN, pinSync2.casN, pinSync2.weN} == 3'h5;
    endsequence

    sequence s_burstStarts;
        burstState == scd_pkg::BURST_WAIT;
    endsequence

    property p_arrayRead;
        @(posedge clk) disable iff (!resetn)
        (s_readSeen and !patternOn) |=> burstState == scd_pkg::BURST_IDLE;
    endproperty
    a_arrayRead: assert property (p_arrayRead)
        else $error("array read started a pattern burst");

    property p_patternRead;
        @(posedge clk) disable iff (!resetn)
        (s_readSeen and patternOn and burstState == scd_pkg::BURST_IDLE)
            |=> s_burstStarts;
    endproperty
    a_patternRead: assert property (p_patternRead)
        else $error("pattern read not redirected");

    property p_lanesMatch;
        @(posedge clk) disable iff (!resetn)
        dqOe |-> dqOut[0] == dqOut[scd_pkg::LANE_W]
            && dqOut[0] == patBits[beatIdx];
    endproperty
    a_lanesMatch: assert property (p_lanesMatch)
        else $error("lane bit 0 differs from pattern bit");

    property p_upperFill;
        @(posedge clk) disable iff (!resetn)
        dqOe |-> dqOut[7:1] == (scd_pkg::FILL_COPY ? {7{dqOut[0]}} : 7'h00);
    endproperty
    a_upperFill: assert property (p_upperFill)
        else $error("upper lane bits wrong");

    property p_firstBeat;
        @(posedge clk) disable iff (!resetn)
        $rose(dqOe) |-> beatIdx == startBeat
            && (beatsLeft == scd_pkg::LEFT_BC4
                || startBeat == scd_pkg::BEAT_FIRST);
    endproperty
    a_firstBeat: assert property (p_firstBeat)
        else $error("burst started on wrong beat");

    property p_predefPattern;
        @(posedge clk) disable iff (!resetn)
        (dqOe && patBits == scd_pkg::PATTERN_LOC0) |-> dqOut[0] == beatIdx[0];
    endproperty
    a_predefPattern: assert property (p_predefPattern)
        else $error("calibration pattern out of order");

    property p_noAutoclose;
        @(posedge clk) disable iff (!resetn)
        (cmdValid && patternOn && $past(patternOn))
            |-> cmdOut.code != scd_pkg::CMD_READ_AUTOCLOSE;
    endproperty
    a_noAutoclose: assert property (p_noAutoclose)
        else $error("auto-close kept in pattern mode");

    property p_latency;
        @(posedge clk) disable iff (!resetn)
        $rose(dqOe) |-> $past(burstState) == scd_pkg::BURST_WAIT
            && $past(latCnt) == 4'h0 && $past(linkRise);
    endproperty
    a_latency: assert property (p_latency)
        else $error("burst started before latency ran out");

endmodule : scd_command_decode

/* design/scd_pkg.sv */
package scd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths of the memory-side pins
    localparam int ADDR_W = 14;
    localparam int BANK_W = 3;
    localparam int LANE_W = 8;
    localparam int DQ_W = 16;

    // address bit positions with a fixed meaning
    localparam int COL2_BIT = 2;
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    localparam int MR3_EN_BIT = 2;
    localparam int MR_FIELD_LSB = 0;

    // mode register selects carried on the bank lines
    localparam logic [2:0] MR0_SEL = 3'h0;
    localparam logic [2:0] MR3_SEL = 3'h3;

    // burst setting field of mode register zero
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_FLY = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;

    // calibration patterns, beat 0 in the lsb
    localparam logic [7:0] PATTERN_LOC0 = 8'hAA;
    localparam logic [7:0] PATTERN_RFU = 8'h00;
    localparam logic [1:0] LOC_PREDEF = 2'h0;

    // upper lane bits copy bit 0 when set, else read as zero
    localparam bit FILL_COPY = 1'b1;

    // read latency in link clock cycles
    localparam logic [3:0] READ_LAT_CYC = 4'h5;

    // beat positions and beats left after the first
    localparam logic [2:0] BEAT_FIRST = 3'h0;
    localparam logic [2:0] NIBBLE_HI = 3'h4;
    localparam logic [2:0] LEFT_BL8 = 3'h7;
    localparam logic [2:0] LEFT_BC4 = 3'h3;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [4:0] {
        CMD_NOP = 5'h00,
        CMD_DESELECT = 5'h01,
        CMD_MODE_SET = 5'h02,
        CMD_REFRESH = 5'h03,
        CMD_SELF_REF_ENTRY = 5'h04,
        CMD_SELF_REF_EXIT = 5'h05,
        CMD_PRECHARGE = 5'h06,
        CMD_ALL_BANK_CLOSE = 5'h07,
        CMD_ROW_OPEN = 5'h08,
        CMD_WRITE = 5'h09,
        CMD_WRITE_AUTOCLOSE = 5'h0A,
        CMD_READ = 5'h0B,
        CMD_READ_AUTOCLOSE = 5'h0C,
        CMD_POWER_DOWN_ENTRY = 5'h0D,
        CMD_POWER_DOWN_EXIT = 5'h0E,
        CMD_LONG_CAL = 5'h0F,
        CMD_SHORT_CAL = 5'h10,
        CMD_HOLD_LOW = 5'h11,
        CMD_ILLEGAL = 5'h12
    } scd_cmd_e;

    typedef enum logic [1:0] {
        BURST_IDLE = 2'b00,
        BURST_WAIT = 2'b01,
        BURST_STREAM = 2'b10
    } scd_burst_e;

    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'b00,
        PWR_DOWN = 2'b01,
        PWR_SELF_REF = 2'b10
    } scd_power_e;

    typedef struct packed {
        logic cke;
        logic csN;
        logic rasN;
        logic casN;
        logic weN;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } scd_pins_s;

    typedef struct packed {
        scd_cmd_e code;
        logic chop;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } scd_cmd_s;

endpackage : scd_pkg

/* dv/scd_ctrl_model.sv */
// controller side of the command link: free-running link clock, pins
// launched on its falling edge so they settle long before the rise
module scd_ctrl_model (
    // system
    input wire logic clk,
    input wire logic resetn,
    // command link toward the decoder
    output logic memClk,
    output scd_pkg::scd_pins_s memPins
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam scd_pkg::scd_pins_s IDLE = scd_pkg::scd_pins_s'(22'h3E0000);

    ////////////////////////////////////////////////////////////////////////
    // next command, loaded by the bench; falls back to deselect once sent
    scd_pkg::scd_pins_s nextPins;
    logic [2:0] halfCnt;
    logic [1:0] warmUp;
    logic isRead;

    assign isRead = !nextPins.csN && nextPins.rasN && !nextPins.casN
        && nextPins.weN;

    // link clock runs free, as a memory clock does between commands
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            memClk <= 1'b0;
            halfCnt <= 3'h0;
            warmUp <= 2'h0;
            memPins <= IDLE;
            nextPins <= IDLE;
        end else if (halfCnt != 3'h4) begin
            halfCnt <= halfCnt + 3'h1;
        end else begin
            halfCnt <= 3'h0;
            memClk <= ~memClk;
            if (memClk && warmUp != 2'h3) begin
                // no commands until the loop has had time to lock
                warmUp <= warmUp + 2'h1;
            end else if (memClk) begin
                memPins <= nextPins;
                // low column bits held at zero on every read
                if (isRead) begin
                    memPins.addr[1:0] <= 2'h0;
                end
                // deselected: address lines wander, never hold old value
                if (nextPins.csN) begin
                    memPins.addr <= ~memPins.addr;
                end
                nextPins.csN <= 1'b1;
            end
        end
    end

endmodule : scd_ctrl_model

/* dv/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic memClk;
    scd_pkg::scd_pins_s memPins;
    logic [scd_pkg::DQ_W-1:0] dqOut;
    logic dqOe;
    logic cmdValid;
    logic patternOn;
    scd_pkg::scd_cmd_s cmdOut;
    scd_pkg::scd_power_e powerState;
    int n_errors = 0;
    int samples_checked = 0;

    // 125 MHz system clock
    always #4 clk = ~clk;

    scd_ctrl_model ctrl_u (.clk(clk), .resetn(resetn), .memClk(memClk),
        .memPins(memPins));
    scd_command_decode dut_u (.clk(clk), .resetn(resetn), .memClk(memClk),
        .memPins(memPins), .dqOut(dqOut), .dqOe(dqOe), .cmdOut(cmdOut),
        .cmdValid(cmdValid), .patternOn(patternOn),
        .powerState(powerState));

    ////////////////////////////////////////////////////////////////////////
    // reporting and comparisons
    task automatic fail(input string msg);
        n_errors++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask : fail

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk_cmd(input scd_pkg::scd_cmd_e got,
                           input scd_pkg::scd_cmd_e exp);
        samples_checked++;
        if (got !== exp) fail($sformatf("code %0h not %0h", got, exp));
    endtask : chk_cmd

    task automatic chk_bit(input logic got, input logic exp, input string w);
        samples_checked++;
        if (got !== exp) fail($sformatf("%s is %b", w, got));
    endtask : chk_bit

    task automatic chk_dq(input logic [scd_pkg::DQ_W-1:0] got, input logic b);
        logic [scd_pkg::DQ_W-1:0] exp;
        exp = scd_pkg::FILL_COPY ? {scd_pkg::DQ_W{b}}
                                 : {2{scd_pkg::LANE_W'(b)}};
        samples_checked++;
        if (got !== exp) fail($sformatf("beat %h not %h", got, exp));
    endtask : chk_dq

    ////////////////////////////////////////////////////////////////////////
    // link access: every wait bounded, a stall ends the run
    task automatic wait_sig(ref logic s, input logic lvl, input int lim);
        int n;
        n = 0;
        while (s !== lvl) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                fail("wait timed out");
                report_and_stop();
            end
        end
    endtask : wait_sig

    task automatic send(input logic cke, input logic [3:0] ctl,
                        input logic [2:0] bank, input logic [13:0] addr);
        @(negedge clk);
        wait_sig(memClk, 1'b0, 20);
        wait_sig(memClk, 1'b1, 20);
        @(posedge clk);
        ctrl_u.nextPins <= scd_pkg::scd_pins_s'({cke, ctl, bank, addr});
        wait_sig(memClk, 1'b0, 20);
        wait_sig(memClk, 1'b1, 20);
        wait_sig(cmdValid, 1'b1, 12);
    endtask : send

    // chop 2 means the command carries no burst length
    task automatic cmd(input logic [3:0] ctl, input logic [2:0] bank,
                       input logic [13:0] addr, input scd_pkg::scd_cmd_e exp,
                       input logic [1:0] chop);
        send(1'b1, ctl, bank, addr);
        chk_cmd(cmdOut.code, exp);
        if (chop != 2'h2) chk_bit(cmdOut.chop, chop[0], "chop");
        chk_bit(cmdOut.bank === bank, 1'b1, "bank");
        if (ctl != 4'h8) chk_bit(cmdOut.addr === addr, 1'b1, "addr");
    endtask : cmd

    // pattern read: latency counted from the decode pulse, beats mid-cell
    task automatic rd_pat(input logic [2:0] bank, input logic [13:0] addr,
                          input int beats, input logic [7:0] pat,
                          input int first);
        int n;
        send(1'b1, 4'h5, bank, addr);
        chk_cmd(cmdOut.code, scd_pkg::CMD_READ);
        for (n = 0; n < 80 && dqOe !== 1'b1; n++) @(negedge clk);
        chk_bit(n >= 49 && n <= 51, 1'b1, "read latency");
        // a burst that never starts would stall every later check
        if (n >= 80) report_and_stop();
        repeat (2) @(negedge clk);
        for (int k = 0; k < beats; k++) begin
            chk_dq(dqOut, pat[first+k]);
            repeat (5) @(negedge clk);
        end
        chk_bit(dqOe, 1'b0, "burst too long");
    endtask : rd_pat

    // array read must not drive the lanes
    task automatic no_data;
        logic seen;
        seen = 1'b0;
        repeat (80) begin
            @(negedge clk);
            seen = seen | dqOe;
        end
        chk_bit(seen, 1'b0, "lanes driven");
    endtask : no_data

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (60) @(negedge clk);
        cmd(4'h0, 3'h0, 14'h0000, scd_pkg::CMD_MODE_SET, 2'h2);
        cmd(4'h1, 3'h0, 14'h0000, scd_pkg::CMD_REFRESH, 2'h2);
        cmd(4'h2, 3'h5, 14'h0000, scd_pkg::CMD_PRECHARGE, 2'h2);
        cmd(4'h2, 3'h5, 14'h0400, scd_pkg::CMD_ALL_BANK_CLOSE, 2'h2);
        cmd(4'h3, 3'h2, 14'h1234, scd_pkg::CMD_ROW_OPEN, 2'h2);
        cmd(4'h4, 3'h1, 14'h0008, scd_pkg::CMD_WRITE, 2'h0);
        cmd(4'h4, 3'h1, 14'h0408, scd_pkg::CMD_WRITE_AUTOCLOSE, 2'h0);
        cmd(4'h5, 3'h1, 14'h0000, scd_pkg::CMD_READ, 2'h0);
        no_data();
        cmd(4'h5, 3'h1, 14'h0400, scd_pkg::CMD_READ_AUTOCLOSE, 2'h0);
        cmd(4'h6, 3'h0, 14'h0400, scd_pkg::CMD_LONG_CAL, 2'h2);
        cmd(4'h6, 3'h0, 14'h0000, scd_pkg::CMD_SHORT_CAL, 2'h2);
        cmd(4'h7, 3'h0, 14'h0000, scd_pkg::CMD_NOP, 2'h2);
        cmd(4'h8, 3'h0, 14'h0000, scd_pkg::CMD_DESELECT, 2'h2);
        // on-the-fly, then fixed four
        cmd(4'h0, 3'h0, 14'h0001, scd_pkg::CMD_MODE_SET, 2'h2);
        cmd(4'h5, 3'h0, 14'h0000, scd_pkg::CMD_READ, 2'h1);
        cmd(4'h5, 3'h0, 14'h1000, scd_pkg::CMD_READ, 2'h0);
        cmd(4'h5, 3'h0, 14'h0400, scd_pkg::CMD_READ_AUTOCLOSE, 2'h1);
        cmd(4'h4, 3'h0, 14'h0000, scd_pkg::CMD_WRITE, 2'h1);
        cmd(4'h4, 3'h0, 14'h1400, scd_pkg::CMD_WRITE_AUTOCLOSE, 2'h0);
        cmd(4'h0, 3'h0, 14'h0002, scd_pkg::CMD_MODE_SET, 2'h2);
        cmd(4'h5, 3'h0, 14'h1000, scd_pkg::CMD_READ, 2'h1);
        cmd(4'h0, 3'h0, 14'h0000, scd_pkg::CMD_MODE_SET, 2'h2);
        // power-down and self refresh
        send(1'b0, 4'h7, 3'h0, 14'h0000);
        chk_cmd(cmdOut.code, scd_pkg::CMD_POWER_DOWN_ENTRY);
        send(1'b0, 4'h8, 3'h0, 14'h0000);
        chk_cmd(cmdOut.code, scd_pkg::CMD_HOLD_LOW);
        chk_bit(powerState === scd_pkg::PWR_DOWN, 1'b1, "power");
        send(1'b1, 4'h7, 3'h0, 14'h0000);
        chk_cmd(cmdOut.code, scd_pkg::CMD_POWER_DOWN_EXIT);
        send(1'b0, 4'h1, 3'h0, 14'h0000);
        chk_cmd(cmdOut.code, scd_pkg::CMD_SELF_REF_ENTRY);
        send(1'b1, 4'h8, 3'h0, 14'h0000);
        chk_cmd(cmdOut.code, scd_pkg::CMD_SELF_REF_EXIT);
        repeat (2) @(negedge clk);
        chk_bit(powerState === scd_pkg::PWR_ACTIVE, 1'b1, "power");
        // pattern mode; only reads and mode sets while it is on
        cmd(4'h0, 3'h3, 14'h0004, scd_pkg::CMD_MODE_SET, 2'h2);
        rd_pat(3'h0, 14'h0000, 8, scd_pkg::PATTERN_LOC0, 0);
        chk_bit(patternOn, 1'b1, "pattern mode");
        rd_pat(3'h7, 14'h2DF8, 8, scd_pkg::PATTERN_LOC0, 0);
        cmd(4'h0, 3'h3, 14'h0000, scd_pkg::CMD_MODE_SET, 2'h2);
        cmd(4'h0, 3'h0, 14'h0001, scd_pkg::CMD_MODE_SET, 2'h2);
        cmd(4'h0, 3'h3, 14'h0004, scd_pkg::CMD_MODE_SET, 2'h2);
        rd_pat(3'h0, 14'h1000, 8, scd_pkg::PATTERN_LOC0, 0);
        rd_pat(3'h0, 14'h0000, 4, scd_pkg::PATTERN_LOC0, 0);
        rd_pat(3'h0, 14'h0004, 4, scd_pkg::PATTERN_LOC0, 4);
        cmd(4'h0, 3'h3, 14'h0005, scd_pkg::CMD_MODE_SET, 2'h2);
        rd_pat(3'h0, 14'h1000, 8, scd_pkg::PATTERN_RFU, 0);
        cmd(4'h0, 3'h3, 14'h0003, scd_pkg::CMD_MODE_SET, 2'h2);
        cmd(4'h5, 3'h0, 14'h1000, scd_pkg::CMD_READ, 2'h0);
        no_data();
        chk_bit(patternOn, 1'b0, "pattern mode");
        report_and_stop();
    end

endmodule : testbench
